// >>> inc/dbfsp_pkg.sv
package dbfsp_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  // host-side bus cycle timing, in ns
  localparam int SETUP_NS = 10;
  localparam int WE_PULSE_NS = 40;
  localparam int HOLD_NS = 10;
  localparam int READ_CYCLE_NS = 70;
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_RECOVERY_NS = 50;
  // least times, rounded up to whole cycles
  localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] WE_CYC = 8'((WE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] READ_CYC = 8'((READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] RST_PULSE_CYC =
    8'((RESET_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] RST_RECOV_CYC =
    8'((RESET_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] SYNC_CYC = 8'h02;
  // own registers
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_OP = 1;
  localparam int CTRL_X16 = 4;
  localparam int CTRL_UNLOCK = 5;
  localparam int CTRL_HRESET = 6;
  localparam logic RST_X16 = 1'b1;
  localparam logic RST_LOCK_N = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // operations
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_SECT = 3'h2;
  localparam logic [2:0] OP_BLOCK = 3'h3;
  localparam logic [2:0] OP_CHIP = 3'h4;
  localparam logic [2:0] OP_SUSP = 3'h5;
  localparam logic [2:0] OP_RESUME = 3'h6;
  localparam logic [2:0] OP_QUERY = 3'h7;
  // device command codes and unlock addresses
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_SECTOR = 8'h50;
  localparam logic [7:0] CMD_BLOCK = 8'h30;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [19:0] ADDR_UNLOCK1 = 20'h00555;
  localparam logic [19:0] ADDR_UNLOCK2 = 20'h002aa;
  localparam logic [19:0] ADDR_QUERY = 20'h00055;
  localparam int TOGGLE_BIT = 6;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_CYC = 6'h02, S_WAIT = 6'h04,
    S_POLL = 6'h08, S_RST = 6'h10, S_REC = 6'h20
  } dbfsp_mst_t;
  typedef enum logic [4:0] {
    C_IDLE = 5'h01, C_SETUP = 5'h02, C_PULSE = 5'h04, C_HOLD = 5'h08, C_READ = 5'h10
  } dbfsp_cst_t;
endpackage : dbfsp_pkg

// >>> rtl/dbfsp_bus_cycle.sv
`timescale 1ns/100ps
module dbfsp_bus_cycle (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic wr,
  input wire logic [19:0] addr,
  input wire logic lsb,
  input wire logic [15:0] wdata,
  input wire logic x16,
  output logic done,
  output logic [15:0] rdata,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [19:0] a,
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe,
  input wire logic [15:0] dq_i
);
  typedef struct packed {
    dbfsp_pkg::dbfsp_cst_t st;
    logic [7:0] cnt;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [19:0] a;
    logic [15:0] dq_o;
    logic [15:0] dq_oe;
    logic [15:0] rdata;
    logic done;
    logic [15:0] s1;
    logic [15:0] s2;
  } dbfsp_cyc_t;
  localparam dbfsp_cyc_t CYC_RESET = '{st: dbfsp_pkg::C_IDLE, ce_n: 1'b1, oe_n: 1'b1,
                                       we_n: 1'b1, default: '0};
  dbfsp_cyc_t s_ff;
  dbfsp_cyc_t nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    nxt_s.s1 = dq_i;
    nxt_s.s2 = s_ff.s1;
    nxt_s.cnt = 8'(s_ff.cnt + 8'h01);
    case (s_ff.st)
      dbfsp_pkg::C_IDLE: begin
        nxt_s.cnt = 8'h00;
        if (start) begin
          nxt_s.a = addr;
          nxt_s.ce_n = 1'b0;
          if (wr) begin
            nxt_s.dq_o = x16 ? wdata : {lsb, 7'h00, wdata[7:0]};
            nxt_s.dq_oe = x16 ? 16'hffff : 16'h80ff;
            nxt_s.st = dbfsp_pkg::C_SETUP;
          end else begin
            nxt_s.dq_o = {lsb, 15'h0000};
            nxt_s.dq_oe = x16 ? 16'h0000 : 16'h8000;
            nxt_s.oe_n = 1'b0;
            nxt_s.st = dbfsp_pkg::C_READ;
          end
        end
      end
      dbfsp_pkg::C_SETUP: begin
        if (s_ff.cnt == 8'(dbfsp_pkg::SETUP_CYC - 8'h01)) begin
          nxt_s.cnt = 8'h00;
          nxt_s.we_n = 1'b0;
          nxt_s.st = dbfsp_pkg::C_PULSE;
        end
      end
      dbfsp_pkg::C_PULSE: begin
        if (s_ff.cnt == 8'(dbfsp_pkg::WE_CYC - 8'h01)) begin
          nxt_s.cnt = 8'h00;
          nxt_s.we_n = 1'b1;
          nxt_s.st = dbfsp_pkg::C_HOLD;
        end
      end
      dbfsp_pkg::C_HOLD: begin
        if (s_ff.cnt == 8'(dbfsp_pkg::HOLD_CYC - 8'h01)) begin
          nxt_s.ce_n = 1'b1;
          nxt_s.dq_oe = 16'h0000;
          nxt_s.done = 1'b1;
          nxt_s.st = dbfsp_pkg::C_IDLE;
        end
      end
      dbfsp_pkg::C_READ: begin
        // sample only after access time plus synchroniser lag
        if (s_ff.cnt == 8'(dbfsp_pkg::READ_CYC + dbfsp_pkg::SYNC_CYC - 8'h01)) begin
          nxt_s.rdata = x16 ? s_ff.s2 : {8'h00, s_ff.s2[7:0]};
          nxt_s.ce_n = 1'b1;
          nxt_s.oe_n = 1'b1;
          nxt_s.dq_oe = 16'h0000;
          nxt_s.done = 1'b1;
          nxt_s.st = dbfsp_pkg::C_IDLE;
        end
      end
      default: nxt_s = CYC_RESET;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= CYC_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign done = s_ff.done;
  assign rdata = s_ff.rdata;
  assign ce_n = s_ff.ce_n;
  assign oe_n = s_ff.oe_n;
  assign we_n = s_ff.we_n;
  assign a = s_ff.a;
  assign dq_o = s_ff.dq_o;
  assign dq_oe = s_ff.dq_oe;

  ////////////////////////////////////////////////////////////////////////////
  property p_we_width;
    @(posedge aclk) disable iff (!aresetn)
    $fell(we_n) |-> (!we_n && !ce_n)[*8] ##1 we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

  property p_no_inhibit;
    @(posedge aclk) disable iff (!aresetn)
    !we_n |-> (oe_n && !ce_n);
  endproperty
  a_no_inhibit: assert property (p_no_inhibit) else $error("write under inhibit");
endmodule : dbfsp_bus_cycle

// >>> rtl/dbfsp_host.sv
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
// Overview of operation
// - status is read only at an address in the busy bank.
// - host raises lock input before a command, holds it until done.
// - an operation cut by hard reset must be restarted by software.
// - program uses two unlock writes and a command write first, erase a six-write sequence.
// - bad sequence aborts; upper data byte driven to valid levels in x16 mode, bits 14:8 released in x8.
// - query entered by three writes or one write to x55, left by exit.
module dbfsp_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [19:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_oe,
  input wire logic [15:0] flash_dq_i,
  output logic flash_width_sel,
  output logic flash_lock_n,
  output logic flash_hard_rst_n,
  input wire logic completion_flag_n
);
  typedef struct packed {
    dbfsp_pkg::dbfsp_mst_t st;
    logic [2:0] op;
    logic [2:0] step;
    logic [20:0] taddr;
    logic [15:0] wdat;
    logic x16;
    logic lock_n;
    logic hrst_n;
    logic hreset_req;
    logic go;
    logic [7:0] cnt;
    logic tog;
    logic have_prev;
    logic polling;
    logic last;
    logic busy_op;
    logic done;
    logic aborted;
    logic [15:0] rd;
    logic cyc_start;
    logic cyc_wr;
    logic [19:0] cyc_addr;
    logic cyc_lsb;
    logic [15:0] cyc_wd;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdat;
    logic rdy1;
    logic rdy2;
  } dbfsp_host_t;
  localparam dbfsp_host_t HOST_RESET = '{st: dbfsp_pkg::S_IDLE, x16: dbfsp_pkg::RST_X16,
                                         lock_n: dbfsp_pkg::RST_LOCK_N, hrst_n: 1'b1,
                                         default: '0};
  dbfsp_host_t s_ff;
  dbfsp_host_t nxt_s;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic wr_fire;
  logic ar_fire;

  function automatic logic is_long_op(input logic [2:0] op);
    return op == dbfsp_pkg::OP_PROG || op == dbfsp_pkg::OP_SECT ||
           op == dbfsp_pkg::OP_BLOCK || op == dbfsp_pkg::OP_CHIP;
  endfunction : is_long_op

  // returns {last, data_cycle, address, data} for one command write
  function automatic logic [37:0] seq_item(input logic [2:0] op, input logic [2:0] st,
                                           input logic [19:0] ta, input logic [15:0] wd);
    logic [19:0] bk;
    logic [19:0] a;
    logic [7:0] c;
    logic [15:0] d;
    logic last;
    logic dat;
    bk = {ta[19:18], 18'h00000};
    a = bk | dbfsp_pkg::ADDR_UNLOCK1;
    c = dbfsp_pkg::CMD_UNLOCK1;
    last = 1'b0;
    dat = 1'b0;
    d = 16'h0000;
    if (!is_long_op(op)) begin
      last = 1'b1;
      a = ta;
      c = (op == dbfsp_pkg::OP_SUSP) ? dbfsp_pkg::CMD_SUSPEND : dbfsp_pkg::CMD_RESUME;
      if (op == dbfsp_pkg::OP_QUERY) begin
        a = bk | dbfsp_pkg::ADDR_QUERY;
        c = dbfsp_pkg::CMD_QUERY;
      end
    end else if (st == 3'h1 || st == 3'h4) begin
      a = bk | dbfsp_pkg::ADDR_UNLOCK2;
      c = dbfsp_pkg::CMD_UNLOCK2;
    end else if (st == 3'h2) begin
      c = (op == dbfsp_pkg::OP_PROG) ? dbfsp_pkg::CMD_PROGRAM : dbfsp_pkg::CMD_ERASE_SETUP;
    end else if (st == 3'h3 && op == dbfsp_pkg::OP_PROG) begin
      a = ta;
      last = 1'b1;
      dat = 1'b1;
    end else if (st == 3'h5) begin
      last = 1'b1;
      c = dbfsp_pkg::CMD_CHIP;
      if (op != dbfsp_pkg::OP_CHIP) begin
        a = ta;
        dat = 1'b1;
        c = (op == dbfsp_pkg::OP_SECT) ? dbfsp_pkg::CMD_SECTOR : dbfsp_pkg::CMD_BLOCK;
      end
    end
    // upper byte clean
    // upper byte of command writes is driven low in x16 mode; in x8 mode only bit 15 of it is driven
    d = (dat && op == dbfsp_pkg::OP_PROG) ? wd : {8'h00, c};
    return {last, dat, a, d};
  endfunction : seq_item

  assign wr_fire = awvalid && wvalid && !s_ff.bvalid;
  assign ar_fire = arvalid && !s_ff.rvalid;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [37:0] item;
    logic t;
    item = seq_item(s_ff.op, s_ff.step, s_ff.taddr[19:0], s_ff.wdat);
    t = cyc_rdata[dbfsp_pkg::TOGGLE_BIT];
    nxt_s = s_ff;
    nxt_s.cyc_start = 1'b0;
    nxt_s.rdy1 = completion_flag_n;
    nxt_s.rdy2 = s_ff.rdy1;
    nxt_s.cnt = 8'(s_ff.cnt + 8'h01);
    case (s_ff.st)
      dbfsp_pkg::S_IDLE: begin
        if (s_ff.hreset_req) begin
          nxt_s.hreset_req = 1'b0;
          nxt_s.hrst_n = 1'b0;
          nxt_s.cnt = 8'h00;
          nxt_s.st = dbfsp_pkg::S_RST;
        end else if (s_ff.go) begin
          nxt_s.go = 1'b0;
          nxt_s.step = 3'h0;
          nxt_s.done = 1'b0;
          nxt_s.aborted = 1'b0;
          nxt_s.polling = 1'b0;
          nxt_s.st = dbfsp_pkg::S_CYC;
        end
      end
      dbfsp_pkg::S_CYC: begin
        nxt_s.cyc_start = 1'b1;
        nxt_s.st = dbfsp_pkg::S_WAIT;
        if (s_ff.op == dbfsp_pkg::OP_READ) begin
          nxt_s.cyc_wr = 1'b0;
          nxt_s.cyc_addr = s_ff.taddr[19:0];
          nxt_s.cyc_lsb = s_ff.taddr[20];
        end else begin
          nxt_s.cyc_wr = 1'b1;
          nxt_s.last = item[37];
          nxt_s.cyc_lsb = item[36] & s_ff.taddr[20];
          nxt_s.cyc_addr = item[35:16];
          nxt_s.cyc_wd = item[15:0];
        end
      end
      dbfsp_pkg::S_POLL: begin
        if (s_ff.hreset_req) begin
          // flag the cut operation for a restart
          nxt_s.aborted = 1'b1;
          nxt_s.hreset_req = 1'b0;
          nxt_s.hrst_n = 1'b0;
          nxt_s.cnt = 8'h00;
          nxt_s.st = dbfsp_pkg::S_RST;
        end else begin
          nxt_s.cyc_start = 1'b1;
          nxt_s.cyc_wr = 1'b0;
          nxt_s.cyc_addr = s_ff.taddr[19:0];
          nxt_s.cyc_lsb = s_ff.taddr[20];
          nxt_s.polling = 1'b1;
          nxt_s.st = dbfsp_pkg::S_WAIT;
        end
      end
      dbfsp_pkg::S_WAIT: begin
        if (cyc_done) begin
          if (s_ff.polling) begin
            // two equal toggle reads end it
            if (s_ff.have_prev && t == s_ff.tog) begin
              nxt_s.done = 1'b1;
              nxt_s.busy_op = 1'b0;
              nxt_s.polling = 1'b0;
              nxt_s.rd = cyc_rdata;
              nxt_s.st = dbfsp_pkg::S_IDLE;
            end else begin
              nxt_s.tog = t;
              nxt_s.have_prev = 1'b1;
              nxt_s.st = dbfsp_pkg::S_POLL;
            end
          end else if (s_ff.op == dbfsp_pkg::OP_READ) begin
            nxt_s.rd = cyc_rdata;
            nxt_s.done = 1'b1;
            nxt_s.st = dbfsp_pkg::S_IDLE;
          end else if (s_ff.last) begin
            nxt_s.busy_op = is_long_op(s_ff.op);
            nxt_s.have_prev = 1'b0;
            nxt_s.done = !is_long_op(s_ff.op);
            nxt_s.st = is_long_op(s_ff.op) ? dbfsp_pkg::S_POLL : dbfsp_pkg::S_IDLE;
          end else begin
            nxt_s.step = 3'(s_ff.step + 3'h1);
            nxt_s.st = dbfsp_pkg::S_CYC;
          end
        end
      end
      dbfsp_pkg::S_RST: begin
        // hold hard reset for its least pulse
        if (s_ff.cnt == 8'(dbfsp_pkg::RST_PULSE_CYC - 8'h01)) begin
          nxt_s.hrst_n = 1'b1;
          nxt_s.cnt = 8'h00;
          nxt_s.st = dbfsp_pkg::S_REC;
        end
      end
      dbfsp_pkg::S_REC: begin
        if (s_ff.cnt == 8'(dbfsp_pkg::RST_RECOV_CYC - 8'h01)) begin
          nxt_s.busy_op = 1'b0;
          nxt_s.polling = 1'b0;
          nxt_s.done = 1'b1;
          nxt_s.st = dbfsp_pkg::S_IDLE;
        end
      end
      default: nxt_s.st = dbfsp_pkg::S_IDLE;
    endcase
    // bus side comes last so a software set wins over a same-cycle clear
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (wr_fire) begin
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = dbfsp_pkg::RESP_OKAY;
      if (awaddr == dbfsp_pkg::REG_CTRL) begin
        if (wdata[dbfsp_pkg::CTRL_HRESET]) begin
          nxt_s.hreset_req = 1'b1;
        end
        // lock level only changes between operations
        if (s_ff.st == dbfsp_pkg::S_IDLE) begin
          nxt_s.go = wdata[dbfsp_pkg::CTRL_START];
          nxt_s.op = wdata[dbfsp_pkg::CTRL_OP +: 3];
          nxt_s.x16 = wdata[dbfsp_pkg::CTRL_X16];
          nxt_s.lock_n = wdata[dbfsp_pkg::CTRL_UNLOCK];
        end
      end else if (awaddr == dbfsp_pkg::REG_ADDR) begin
        if (s_ff.st == dbfsp_pkg::S_IDLE) begin
          nxt_s.taddr = wdata[20:0];
        end
      end else if (awaddr == dbfsp_pkg::REG_WDATA) begin
        if (s_ff.st == dbfsp_pkg::S_IDLE) begin
          nxt_s.wdat = wdata[15:0];
        end
      end else if (awaddr != dbfsp_pkg::REG_STATUS && awaddr != dbfsp_pkg::REG_RDATA) begin
        nxt_s.bresp = dbfsp_pkg::RESP_SLVERR;
      end
    end
    if (ar_fire) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = dbfsp_pkg::RESP_OKAY;
      nxt_s.rdat = 32'h00000000;
      if (araddr == dbfsp_pkg::REG_CTRL) begin
        nxt_s.rdat = {26'h0, s_ff.lock_n, s_ff.x16, s_ff.op, 1'b0};
      end else if (araddr == dbfsp_pkg::REG_ADDR) begin
        nxt_s.rdat = {11'h0, s_ff.taddr};
      end else if (araddr == dbfsp_pkg::REG_WDATA) begin
        nxt_s.rdat = {16'h0, s_ff.wdat};
      end else if (araddr == dbfsp_pkg::REG_STATUS) begin
        nxt_s.rdat = {27'h0, s_ff.busy_op, s_ff.rdy2, s_ff.aborted, s_ff.done,
                      s_ff.st != dbfsp_pkg::S_IDLE};
      end else if (araddr == dbfsp_pkg::REG_RDATA) begin
        nxt_s.rdat = {16'h0, s_ff.rd};
      end else begin
        nxt_s.rresp = dbfsp_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= HOST_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  dbfsp_bus_cycle u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(s_ff.cyc_start),
    .wr(s_ff.cyc_wr),
    .addr(s_ff.cyc_addr),
    .lsb(s_ff.cyc_lsb),
    .wdata(s_ff.cyc_wd),
    .x16(s_ff.x16),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .ce_n(flash_ce_n),
    .oe_n(flash_oe_n),
    .we_n(flash_we_n),
    .a(flash_addr),
    .dq_o(flash_dq_o),
    .dq_oe(flash_dq_oe),
    .dq_i(flash_dq_i)
  );

  assign awready = wr_fire;
  assign wready = wr_fire;
  assign bvalid = s_ff.bvalid;
  assign bresp = s_ff.bresp;
  assign arready = !s_ff.rvalid;
  assign rvalid = s_ff.rvalid;
  assign rresp = s_ff.rresp;
  assign rdata = s_ff.rdat;
  assign flash_width_sel = s_ff.x16;
  assign flash_lock_n = s_ff.lock_n;
  assign flash_hard_rst_n = s_ff.hrst_n;

  ////////////////////////////////////////////////////////////////////////////
  property p_poll_bank;
    @(posedge aclk) disable iff (!aresetn)
    (s_ff.cyc_start && s_ff.polling) |=>
      (flash_addr == s_ff.taddr[19:0] && flash_addr[19:18] == s_ff.taddr[19:18]);
  endproperty
  a_poll_bank: assert property (p_poll_bank) else $error("poll outside busy bank");

  property p_lock_stable;
    @(posedge aclk) disable iff (!aresetn)
    (s_ff.st != dbfsp_pkg::S_IDLE) |=> $stable(flash_lock_n);
  endproperty
  a_lock_stable: assert property (p_lock_stable) else $error("lock moved mid operation");

  property p_abort_flag;
    @(posedge aclk) disable iff (!aresetn)
    ($fell(flash_hard_rst_n) && s_ff.busy_op) |-> s_ff.aborted;
  endproperty
  a_abort_flag: assert property (p_abort_flag) else $error("cut operation not flagged");

  property p_first_unlock;
    @(posedge aclk) disable iff (!aresetn)
    (s_ff.cyc_start && s_ff.cyc_wr && s_ff.step == 3'h0 && is_long_op(s_ff.op)) |->
      (s_ff.cyc_wd[7:0] == dbfsp_pkg::CMD_UNLOCK1) ##1 !flash_ce_n;
  endproperty
  a_first_unlock: assert property (p_first_unlock) else $error("sequence lacks unlock");

  property p_erase_len;
    @(posedge aclk) disable iff (!aresetn)
    (s_ff.cyc_start && s_ff.last && is_long_op(s_ff.op)) |->
      (s_ff.step == ((s_ff.op == dbfsp_pkg::OP_PROG) ? 3'h3 : 3'h5));
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("sequence length wrong");

  property p_upper_byte;
    @(posedge aclk) disable iff (!aresetn)
    (s_ff.cyc_start && s_ff.cyc_wr && !(s_ff.op == dbfsp_pkg::OP_PROG && s_ff.step == 3'h3))
      |-> (s_ff.cyc_wd[15:8] == 8'h00);
  endproperty
  a_upper_byte: assert property (p_upper_byte) else $error("upper byte not clean");

  property p_query;
    @(posedge aclk) disable iff (!aresetn)
    (s_ff.cyc_start && s_ff.op == dbfsp_pkg::OP_QUERY) |->
      (s_ff.cyc_addr[17:0] == dbfsp_pkg::ADDR_QUERY[17:0] &&
       s_ff.cyc_wd[7:0] == dbfsp_pkg::CMD_QUERY && s_ff.cyc_addr[19:18] == s_ff.taddr[19:18]);
  endproperty
  a_query: assert property (p_query) else $error("query entry write wrong");

  property p_toggle_done;
    @(posedge aclk) disable iff (!aresetn)
    (s_ff.st == dbfsp_pkg::S_WAIT && s_ff.polling && cyc_done) |=>
      ((s_ff.st == dbfsp_pkg::S_IDLE) == ($past(s_ff.have_prev) &&
       $past(cyc_rdata[dbfsp_pkg::TOGGLE_BIT]) == $past(s_ff.tog)));
  endproperty
  a_toggle_done: assert property (p_toggle_done) else $error("completion misjudged");
endmodule : dbfsp_host

// >>> verif/dbfsp_flash_model.sv
`timescale 1ns/100ps
module dbfsp_flash_model (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [15:0] dq,
  input wire logic hard_rst_n,
  output logic [15:0] rd,
  output logic rd_en,
  output logic completion_flag_n
);
  logic [1:0] n_wr = 2'h0;
  logic [15:0] wd = 16'h0000;
  logic tog = 1'b0;
  int busy = 0;
  always @(posedge we_n or negedge oe_n or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      busy = 0;
      n_wr = 2'h0;
    end else if (!oe_n) begin
      if (busy > 0) begin
        tog = ~tog;
        busy--;
      end
    end else if (!ce_n && busy == 0) begin
      if (n_wr == 2'h3) begin
        wd = dq;
        busy = 4;
      end
      n_wr = (n_wr == 2'h0 && dq[7:0] != 8'haa) ? 2'h0 : n_wr + 2'h1;
    end
  end
  assign rd_en = !ce_n && !oe_n;
  assign rd = (busy > 0) ? {8'h00, ~wd[7], tog, 6'h00} : wd;
  assign completion_flag_n = !(busy > 0);
endmodule : dbfsp_flash_model

// >>> verif/dbfsp_host_tb.sv
`timescale 1ns/100ps
module dbfsp_host_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n;
  logic wsel, lock_n, hrst_n, rd_en, cflag_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  logic [19:0] fa;
  logic [15:0] dq_o, dq_oe, dq_bus, m_rd;
  logic [15:0] dq_last = 16'h0;
  int bad_count = 0, n_compared = 0, cyc = 0, we_lo = 0, rst_lo = 0, s;
  always #2.5 aclk = ~aclk;
  // released lines show the model's read data while it reads, else the inverse of the last value
  assign dq_bus = (dq_oe & dq_o) | (~dq_oe & (rd_en ? m_rd : ~dq_last));
  always @(posedge aclk) begin
    dq_last <= dq_bus;
    cyc <= cyc + 1;
    we_lo <= we_lo + int'(!we_n);
    rst_lo <= rst_lo + int'(!hrst_n);
    if (cyc == 30000) begin
      bad_count++;
      complete_run();
    end
  end
  dbfsp_host i_dbfsp_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_addr(fa), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_bus),
    .flash_width_sel(wsel), .flash_lock_n(lock_n), .flash_hard_rst_n(hrst_n),
    .completion_flag_n(cflag_n));
  dbfsp_flash_model i_dbfsp_flash_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .dq(dq_bus), .hard_rst_n(hrst_n), .rd(m_rd), .rd_en(rd_en), .completion_flag_n(cflag_n));
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (!ok) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp === er, "bresp");
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] ad, input logic [1:0] er);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    chk(rresp === er, "rresp");
  endtask : axi_rd
  task automatic wait_done();
    do axi_rd(dbfsp_pkg::REG_STATUS, dbfsp_pkg::RESP_OKAY); while (v[1] !== 1'b1);
  endtask : wait_done
  task automatic t_program();
    s = we_lo;
    axi_wr(dbfsp_pkg::REG_ADDR, 32'h00040123, dbfsp_pkg::RESP_OKAY);
    axi_wr(dbfsp_pkg::REG_WDATA, 32'h00005a3c, dbfsp_pkg::RESP_OKAY);
    axi_wr(dbfsp_pkg::REG_CTRL, 32'h00000033, dbfsp_pkg::RESP_OKAY);
    wait_done();
    chk(v[3] === 1'b1, "completion pin");
    chk(wsel === 1'b1 && lock_n === 1'b1, "width or lock pin");
    chk(we_lo - s == 4 * int'(dbfsp_pkg::WE_CYC), "strobe cycles");
    axi_rd(dbfsp_pkg::REG_RDATA, dbfsp_pkg::RESP_OKAY);
    chk(v[15:0] === 16'h5a3c, "program data");
  endtask : t_program
  task automatic t_hreset();
    s = rst_lo;
    axi_wr(dbfsp_pkg::REG_CTRL, 32'h00000040, dbfsp_pkg::RESP_OKAY);
    do @(posedge aclk); while (hrst_n !== 1'b0);
    do @(posedge aclk); while (hrst_n !== 1'b1);
    chk(rst_lo - s == int'(dbfsp_pkg::RST_PULSE_CYC), "reset pulse");
    wait_done();
    chk(v[2] === 1'b0, "aborted flag");
    chk(wsel === 1'b0 && lock_n === 1'b0, "width or lock pin");
  endtask : t_hreset
  task automatic complete_run();
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_program();
    axi_wr(8'h20, 32'h0, dbfsp_pkg::RESP_SLVERR);
    axi_rd(8'h20, dbfsp_pkg::RESP_SLVERR);
    t_hreset();
    complete_run();
  end
endmodule : dbfsp_host_tb
